// >>> registered_bus_transceiver.sv
// Purpose: Registered 8-bit transceiver between buses A and B, with a
//          capture log FIFO.
// Assumes: Bus, control and capture clock pins are asynchronous to i_core_clk and are held stable for
//          at least three core cycles around each capture clock rise.
// Notes: Storage registers carry no reset; the FIFO depth must be a power
//        of two.
`include "xcvr_regs.svh"
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Capture log FIFO
// ----------------------------------------------------------------------
module xcvr_log_fifo #(
  parameter int WIDTH = 2 * `XCVR_DATA_W + 2,
  parameter int DEPTH = `XCVR_LOG_DEPTH
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW-1:0] rd_ptr_nxt;
  logic [AW:0] count_nxt;
  logic push;
  logic pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb
  begin
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    count_nxt = count_r;
    if (push && !pop)
    begin
      count_nxt = count_r + 1'b1;
    end
    else if (pop && !push)
    begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  // Flags and head word are registered so the ports come from flops.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_in_ready <= `XCVR_BIT_RST;
      o_out_valid <= `XCVR_BIT_RST;
      o_out_data <= '0;
    end
    else
    begin
      o_in_ready <= (count_nxt != (AW + 1)'(DEPTH));
      o_out_valid <= (count_nxt != '0);
      if (push && (rd_ptr_nxt == wr_ptr_r))
      begin
        o_out_data <= i_in_data;
      end
      else
      begin
        o_out_data <= mem[rd_ptr_nxt];
      end
    end
  end

endmodule // xcvr_log_fifo

// Behaviour
// - Two separate eight-bit storage registers, one per source bus.
// - A register loads only on its own capture clock rising edge.
// - A-side register loads from A, clocked by A clock, shown on B.
// - B-side register loads from B, clocked by B clock, shown on A.
// - Every capture clock rise stores, whatever enable and direction say.
// - Enable high: neither bus driven, whatever direction and selects.
// - With both buses undriven, captures still happen independently.
// - Enabled, direction low, select low: A driven with live B.
// - Enabled, direction low, select high: A driven from B register.
// - Enabled, direction high, select low: B driven with live A.
// - Enabled, direction high, select high: B driven from A register.
// - Never drive both buses; direction picks exactly one when enabled.
// - Input port data may be stored in either register or both.
module registered_bus_transceiver #(
  parameter int DATA_W = `XCVR_DATA_W,
  parameter int LOG_DEPTH = `XCVR_LOG_DEPTH
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Control pins
  input wire logic i_out_en_b,
  input wire logic i_dir,
  input wire logic i_a_to_b_source_select,
  input wire logic i_b_to_a_source_select,
  // Capture clock pins
  input wire logic i_a_capture_clock,
  input wire logic i_b_capture_clock,
  // A bus pins
  input wire logic [DATA_W-1:0] i_a_bus,
  output logic [DATA_W-1:0] o_a_bus,
  output logic o_a_oe,
  // B bus pins
  input wire logic [DATA_W-1:0] i_b_bus,
  output logic [DATA_W-1:0] o_b_bus,
  output logic o_b_oe,
  // Capture log: {a_hit, b_hit, a_data, b_data}
  output logic o_log_valid,
  output logic [2*DATA_W+1:0] o_log_data,
  input wire logic i_log_ready,
  output logic o_log_space,
  output logic o_log_lost
);

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  logic [`XCVR_CTL_W-1:0] ctl_meta_r;
  logic [`XCVR_CTL_W-1:0] ctl_sync_r;
  logic [1:0] cap_meta_r;
  logic [1:0] cap_sync_r;
  logic [1:0] cap_prev_r;
  logic [DATA_W-1:0] a_meta_r;
  logic [DATA_W-1:0] a_in_s;
  logic [DATA_W-1:0] b_meta_r;
  logic [DATA_W-1:0] b_in_s;

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ctl_meta_r <= `XCVR_CTL_RST;
      ctl_sync_r <= `XCVR_CTL_RST;
    end
    else
    begin
      ctl_meta_r <= {i_out_en_b, i_dir, i_a_to_b_source_select,
                     i_b_to_a_source_select};
      ctl_sync_r <= ctl_meta_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cap_meta_r <= `XCVR_CLK_RST;
      cap_sync_r <= `XCVR_CLK_RST;
      cap_prev_r <= `XCVR_CLK_RST;
    end
    else
    begin
      cap_meta_r <= {i_a_capture_clock, i_b_capture_clock};
      cap_sync_r <= cap_meta_r;
      cap_prev_r <= cap_sync_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      a_meta_r <= '0;
      a_in_s <= '0;
      b_meta_r <= '0;
      b_in_s <= '0;
    end
    else
    begin
      a_meta_r <= i_a_bus;
      a_in_s <= a_meta_r;
      b_meta_r <= i_b_bus;
      b_in_s <= b_meta_r;
    end
  end

  logic oe_b_s;
  logic dir_s;
  logic a2b_sel_s;
  logic b2a_sel_s;
  logic a_rise;
  logic b_rise;

  assign oe_b_s = ctl_sync_r[`XCVR_CTL_OE_B];
  assign dir_s = ctl_sync_r[`XCVR_CTL_DIR];
  assign a2b_sel_s = ctl_sync_r[`XCVR_CTL_A2B_SEL];
  assign b2a_sel_s = ctl_sync_r[`XCVR_CTL_B2A_SEL];
  assign a_rise = cap_sync_r[1] && !cap_prev_r[1];
  assign b_rise = cap_sync_r[0] && !cap_prev_r[0];

  // --------------------------------------------------------------------
  // Storage registers
  // --------------------------------------------------------------------
  logic [DATA_W-1:0] a_store_r;
  logic [DATA_W-1:0] b_store_r;

  always_ff @(posedge i_core_clk)
  begin
    if (a_rise)
    begin
      a_store_r <= a_in_s;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (b_rise)
    begin
      b_store_r <= b_in_s;
    end
  end

  // --------------------------------------------------------------------
  // Output drive
  // --------------------------------------------------------------------
  xcvr_pkg::drive_mode_e mode_nxt;

  // Enable and direction choose one bus or none.
  always_comb
  begin
    mode_nxt = xcvr_pkg::drive_none;
    if (!oe_b_s)
    begin
      mode_nxt = dir_s ? xcvr_pkg::drive_b : xcvr_pkg::drive_a;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_a_oe <= `XCVR_BIT_RST;
      o_b_oe <= `XCVR_BIT_RST;
    end
    else
    begin
      case (mode_nxt)
        xcvr_pkg::drive_a:
        begin
          o_a_oe <= 1'b1;
          o_b_oe <= `XCVR_LOW;
        end
        xcvr_pkg::drive_b:
        begin
          o_a_oe <= `XCVR_LOW;
          o_b_oe <= 1'b1;
        end
        default:
        begin
          o_a_oe <= `XCVR_LOW;
          o_b_oe <= `XCVR_LOW;
        end
      endcase
    end
  end

  // A bus from live B or the B-side store.
  // B bus from live A or the A-side store.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_a_bus <= '0;
      o_b_bus <= '0;
    end
    else
    begin
      o_a_bus <= b2a_sel_s ? b_store_r : b_in_s;
      o_b_bus <= a2b_sel_s ? a_store_r : a_in_s;
    end
  end

  // --------------------------------------------------------------------
  // Capture log
  // --------------------------------------------------------------------
  logic log_push;
  logic log_space;

  assign log_push = a_rise || b_rise;
  assign o_log_space = log_space;

  // A capture is always stored; only its log entry is lost when full.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_log_lost <= `XCVR_BIT_RST;
    end
    else
    begin
      o_log_lost <= log_push && !log_space;
    end
  end

  xcvr_log_fifo #(
    .WIDTH(2 * DATA_W + 2),
    .DEPTH(LOG_DEPTH)
  ) u_log_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(log_push),
    .i_in_data({a_rise, b_rise, a_in_s, b_in_s}),
    .o_in_ready(log_space),
    .o_out_valid(o_log_valid),
    .o_out_data(o_log_data),
    .i_out_ready(i_log_ready)
  );

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  // Single driven bus.
  bus_exclusive_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !(o_a_oe && o_b_oe))
    else $error("both buses driven");

  isolate_no_drive_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    oe_b_s |=> (!o_a_oe && !o_b_oe))
    else $error("bus driven while disabled");

  a_store_load_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    a_rise |=> (a_store_r == $past(a_in_s)))
    else $error("A store missed a capture");

  b_store_load_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    b_rise |=> (b_store_r == $past(b_in_s)))
    else $error("B store missed a capture");

  // Stores power up unknown, so hold checks start at their first capture.
  logic a_seen_r;
  logic b_seen_r;

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      a_seen_r <= `XCVR_BIT_RST;
      b_seen_r <= `XCVR_BIT_RST;
    end
    else
    begin
      if (a_rise)
      begin
        a_seen_r <= 1'b1;
      end
      if (b_rise)
      begin
        b_seen_r <= 1'b1;
      end
    end
  end

  store_hold_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (a_seen_r && !a_rise) |=> $stable(a_store_r))
    else $error("A store changed without a rise");

  b_store_hold_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (b_seen_r && !b_rise) |=> $stable(b_store_r))
    else $error("B store changed without a rise");

  capture_isolated_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (oe_b_s && a_rise && b_rise) |=>
      (a_store_r == $past(a_in_s) && b_store_r == $past(b_in_s)))
    else $error("capture lost in isolation");

  live_b_to_a_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!oe_b_s && !dir_s && !b2a_sel_s) |=>
      (o_a_oe && !o_b_oe && o_a_bus == $past(b_in_s)))
    else $error("A bus not showing live B");

  stored_b_to_a_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!oe_b_s && !dir_s && b2a_sel_s) |=>
      (o_a_oe && o_a_bus == $past(b_store_r)))
    else $error("A bus not showing B store");

  live_a_to_b_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!oe_b_s && dir_s && !a2b_sel_s) |=>
      (o_b_oe && !o_a_oe && o_b_bus == $past(a_in_s)))
    else $error("B bus not showing live A");

  stored_a_to_b_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!oe_b_s && dir_s && a2b_sel_s) |=>
      (o_b_oe && o_b_bus == $past(a_store_r)))
    else $error("B bus not showing A store");

  // Input port capture while the other bus is driven.
  capture_driven_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!oe_b_s && dir_s && a_rise) ##1 (!oe_b_s && dir_s && a2b_sel_s) |=>
      (o_b_bus == $past(a_in_s, 2)))
    else $error("captured A not presented on B");

endmodule // registered_bus_transceiver

`default_nettype wire

// >>> xcvr_regs.svh
// Purpose: Named constants for the registered bus transceiver.
// Assumes: Included by its bare name from the design file.
// Notes: Holds definitions only.
`ifndef XCVR_REGS_SVH
`define XCVR_REGS_SVH

// ----------------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------------
`define XCVR_DATA_W 8
`define XCVR_LOG_DEPTH 8
`define XCVR_CTL_W 4

// ----------------------------------------------------------------------
// Control bit positions in the synchronised control word
// ----------------------------------------------------------------------
`define XCVR_CTL_OE_B 3
`define XCVR_CTL_DIR 2
`define XCVR_CTL_A2B_SEL 1
`define XCVR_CTL_B2A_SEL 0

// ----------------------------------------------------------------------
// Reset values and the low level
// ----------------------------------------------------------------------
`define XCVR_CTL_RST 4'h8
`define XCVR_CLK_RST 2'h0
`define XCVR_BIT_RST 1'b0
`define XCVR_LOW 1'b0

`endif

// >>> xcvr_pkg.sv
// Purpose: Types shared by the registered bus transceiver.
// Assumes: Nothing.
// Notes: Constants live in xcvr_regs.svh.
`default_nettype none

package xcvr_pkg;

  // Which bus, if either, the block drives.
  typedef enum logic [1:0] {drive_none, drive_a, drive_b} drive_mode_e;

endpackage

`default_nettype wire

// >>> xcvr_bus_partner.sv
// Purpose: Far-side model of parallel buses A and B.
// Assumes: Device output enables are high while the device drives a bus.
// Notes: The far side lets go of a bus whenever the device drives it.
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Bus partner
// ----------------------------------------------------------------------
module xcvr_bus_partner (
  // Far-side drive values
  input wire logic [7:0] i_a_val,
  input wire logic [7:0] i_b_val,
  // Device side of bus A
  input wire logic [7:0] i_a_dev,
  input wire logic i_a_oe,
  // Device side of bus B
  input wire logic [7:0] i_b_dev,
  input wire logic i_b_oe,
  // Resolved bus levels
  output logic [7:0] o_a_wire,
  output logic [7:0] o_b_wire
);
  // Only one party drives each wire, so the level is never contended.
  assign o_a_wire = i_a_oe ? i_a_dev : i_a_val;
  assign o_b_wire = i_b_oe ? i_b_dev : i_b_val;
endmodule // xcvr_bus_partner

`default_nettype wire

// >>> registered_bus_transceiver_test.sv
// Purpose: Self-checking bench for the registered bus transceiver.
// Assumes: Pins change at the falling edge and are held several cycles.
// Notes: Outputs are judged six cycles after the pins settle.
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module registered_bus_transceiver_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic en_b = 1'b1;
  logic dir = 1'b0;
  logic a2b_sel = 1'b0;
  logic b2a_sel = 1'b0;
  logic cpa = 1'b0;
  logic cpb = 1'b0;
  logic log_rdy = 1'b0;
  logic [7:0] a_val = 8'h00;
  logic [7:0] b_val = 8'h00;
  logic [7:0] a_wire, b_wire, a_dev, b_dev;
  logic a_oe, b_oe, log_valid, log_space, log_lost;
  logic [17:0] log_data;
  int n_errors = 0;
  int n_tests = 0;
  int n_lost = 0;

  registered_bus_transceiver dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_out_en_b(en_b), .i_dir(dir),
    .i_a_to_b_source_select(a2b_sel), .i_b_to_a_source_select(b2a_sel),
    .i_a_capture_clock(cpa), .i_b_capture_clock(cpb),
    .i_a_bus(a_wire), .o_a_bus(a_dev), .o_a_oe(a_oe),
    .i_b_bus(b_wire), .o_b_bus(b_dev), .o_b_oe(b_oe),
    .o_log_valid(log_valid), .o_log_data(log_data),
    .i_log_ready(log_rdy), .o_log_space(log_space), .o_log_lost(log_lost)
  );

  xcvr_bus_partner u_bus (
    .i_a_val(a_val), .i_b_val(b_val), .i_a_dev(a_dev), .i_a_oe(a_oe),
    .i_b_dev(b_dev), .i_b_oe(b_oe), .o_a_wire(a_wire), .o_b_wire(b_wire)
  );

  initial
  begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (log_lost === 1'b1)
      n_lost <= n_lost + 1;
  end

  task automatic check(input string what, input logic [17:0] seen,
                       input logic [17:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Data is changed while the capture clock is high, four cycles before it falls.
  task automatic cap(input logic [7:0] a, input logic [7:0] b,
                     input logic ca, input logic cb);
    a_val = a;
    b_val = b;
    repeat (6) @(negedge clk);
    cpa = ca;
    cpb = cb;
    repeat (4) @(negedge clk);
    a_val = ~a;
    b_val = ~b;
    repeat (4) @(negedge clk);
    cpa = 1'b0;
    cpb = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic show(input logic d, input logic s);
    en_b = 1'b0;
    dir = d;
    a2b_sel = s;
    b2a_sel = s;
    repeat (6) @(negedge clk);
  endtask

  task automatic t_isolate();
    a2b_sel = 1'b1;
    b2a_sel = 1'b1;
    cap(8'h11, 8'h22, 1'b1, 1'b1);
    for (int d = 0; d < 2; d++)
    begin
      dir = d[0];
      repeat (6) @(negedge clk);
      check("a_oe", a_oe, 0);
      check("b_oe", b_oe, 0);
    end
    cap(8'h33, 8'h44, 1'b1, 1'b0);
  endtask

  task automatic t_stored();
    show(1'b0, 1'b1);
    check("a_oe", a_oe, 1);
    check("b_oe", b_oe, 0);
    check("a_dev", a_dev, 8'h22);
    show(1'b1, 1'b1);
    check("a_oe", a_oe, 0);
    check("b_oe", b_oe, 1);
    check("b_dev", b_dev, 8'h33);
  endtask

  task automatic t_live();
    b_val = 8'h5A;
    show(1'b0, 1'b0);
    check("a_dev", a_dev, 8'h5A);
    a_val = 8'hC3;
    show(1'b1, 1'b0);
    check("b_dev", b_dev, 8'hC3);
  endtask

  // A follows live B while both stores capture the same word.
  task automatic t_both();
    b_val = 8'h9C;
    show(1'b0, 1'b0);
    cap(8'h00, 8'h9C, 1'b1, 1'b1);
    show(1'b1, 1'b1);
    check("b_dev", b_dev, 8'h9C);
    // A is the input port while B shows the A store; capture A only.
    cap(8'h6B, 8'h00, 1'b1, 1'b0);
    check("b_dev", b_dev, 8'h6B);
    show(1'b0, 1'b1);
    check("a_dev", a_dev, 8'h9C);
  endtask

  task automatic t_log();
    int lost0;
    en_b = 1'b1;
    log_rdy = 1'b1;
    repeat (20) @(negedge clk);
    log_rdy = 1'b0;
    check("log_valid", log_valid, 0);
    for (int k = 0; k < 8; k++)
      cap(8'(k), ~8'(k), 1'b1, 1'b1);
    check("log_space", log_space, 0);
    lost0 = n_lost;
    cap(8'hEE, 8'hDD, 1'b1, 1'b1);
    check("lost", 18'(n_lost - lost0), 1);
    for (int k = 0; k < 8; k++)
    begin
      check("log_data", log_data, {2'b11, 8'(k), ~8'(k)});
      log_rdy = 1'b1;
      @(negedge clk);
      log_rdy = 1'b0;
      repeat (2) @(negedge clk);
    end
    check("log_valid", log_valid, 0);
    check("log_space", log_space, 1);
    show(1'b1, 1'b1);
    check("b_dev", b_dev, 8'hEE);
  endtask

  initial
  begin
    repeat (5) @(negedge clk);
    check("a_oe", a_oe, 0);
    check("b_oe", b_oe, 0);
    rst_b = 1'b1;
    t_isolate();
    t_stored();
    t_live();
    t_both();
    t_log();
    print_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule // registered_bus_transceiver_test

`default_nettype wire
